// File: include/bss_map.svh
// register map, field positions, reset values and timing counts of the supervisor
`ifndef BSS_MAP_SVH
`define BSS_MAP_SVH

`define BSS_CLK_MHZ        50
// register offsets (byte addresses)
`define BSS_REG_CTRL       8'h00
`define BSS_REG_PERIOD     8'h04
`define BSS_REG_STATUS     8'h08
// field positions and reset values
`define BSS_CTRL_EN_BIT    0
`define BSS_CTRL_RESET     1'b1
`define BSS_PERIOD_RESET   16'h0064
// timing in its own unit, then in cycles; the sync window and the duty-over step in cycles only
`define BSS_T_MIN_ON_NS    70
`define BSS_MIN_ON_CYC     ((`BSS_T_MIN_ON_NS * `BSS_CLK_MHZ + 999) / 1000)
`define BSS_T_MIN_OFF_NS   120
`define BSS_MIN_OFF_CYC    ((`BSS_T_MIN_OFF_NS * `BSS_CLK_MHZ + 999) / 1000)
`define BSS_T_QUAL_US      15
`define BSS_QUAL_CYC       (`BSS_T_QUAL_US * `BSS_CLK_MHZ)
`define BSS_T_REL_US       120
`define BSS_REL_CYC        (`BSS_T_REL_US * `BSS_CLK_MHZ)
`define BSS_T_SS_US        500
`define BSS_SS_CYC         (`BSS_T_SS_US * `BSS_CLK_MHZ)
`define BSS_T_HICCUP_US    7500
`define BSS_HICCUP_CYC     (`BSS_T_HICCUP_US * `BSS_CLK_MHZ)
`define BSS_SYNC_WIN_CYC   10'h1f4
`define BSS_DO_STEP_CYC    4'h8

`endif

// File: include/bss_pkg.sv
// types of the buck supervisor: sequencer states and the packed state record
package bss_pkg;

    typedef enum logic [2:0] {
        SEQ_OFF    = 3'b000,
        SEQ_LOCK   = 3'b001,
        SEQ_SOFT   = 3'b010,
        SEQ_RUN    = 3'b011,
        SEQ_HICCUP = 3'b100
    } bss_seq_t;

    typedef struct packed {
        bss_seq_t    seq;
        logic [19:0] seq_cnt;
        logic        supply_low_lockout;
        logic        input_high_lockout;
        logic        output_low_detect;
        logic        output_high_detect;
        logic [9:0]  uv_cnt;
        logic [9:0]  ov_cnt;
        logic [19:0] pg_cnt;
        logic        pg_oen;
        logic        pg_out;
        logic        mode_q;
        logic [9:0]  sync_win;
        logic [1:0]  sync_edges;
        logic        sync;
        logic        forced_pwm;
        logic [15:0] osc_cnt;
        logic [1:0]  tick_cnt;
        logic [1:0]  div;
        logic [3:0]  do_cnt;
        logic        min_off_seen;
        logic        gate;
        logic [15:0] on_cnt;
        logic [18:0] on_len;
        logic        ctrl_en;
        logic [15:0] period;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } bss_state_t;

endpackage : bss_pkg

// File: rtl/bss_sequencer.sv
// supervisor and pulse gating for a synchronous step-down converter
`timescale 1ns/1ns
`include "bss_map.svh"
module bss_sequencer #(
    parameter int SS_CYCLES     = `BSS_SS_CYC,
    parameter int HICCUP_CYCLES = `BSS_HICCUP_CYC,
    parameter int REL_CYCLES    = `BSS_REL_CYC
) (
    // clock, reset, clock enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // system controller pins
    input  wire logic        chip_enable,
    input  wire logic        mode_pin,
    output logic             power_ok_flag_out,
    output logic             power_ok_flag_oen,
    output logic             forced_pwm,
    output logic             sync_locked,
    // comparator results, already synchronous
    input  wire logic        supply_below_lo,
    input  wire logic        supply_above_hi,
    input  wire logic        input_above_hi,
    input  wire logic        input_below_lo,
    input  wire logic        fb_below_uv,
    input  wire logic        fb_above_uv_rel,
    input  wire logic        fb_above_ov,
    input  wire logic        fb_below_ov_rel,
    input  wire logic        current_limit,
    input  wire logic        thermal_hot,
    input  wire logic        min_off_hit,
    // pulse request from the loop and the high-side gate
    input  wire logic [15:0] on_request,
    output logic             hs_gate
);

    localparam logic [15:0] MIN_ON  = 16'(`BSS_MIN_ON_CYC);
    localparam logic [18:0] MIN_OFF = 19'(`BSS_MIN_OFF_CYC);
    localparam logic [9:0]  QUAL    = 10'(`BSS_QUAL_CYC);

    bss_pkg::bss_state_t r;
    bss_pkg::bss_state_t next_r;

    logic        en;
    logic        blocked;
    logic        sw_ok;
    logic        mode_edge;
    logic        tick;
    logic        cyc_start;
    logic [18:0] span;
    logic [18:0] max_on;
    logic        wr;
    logic        access;

    // combinational helpers shared by the state update and the checks
    always_comb begin
        en        = chip_enable & r.ctrl_en;
        blocked   = r.supply_low_lockout | r.input_high_lockout | thermal_hot;
        sw_ok     = (r.seq == bss_pkg::SEQ_SOFT || r.seq == bss_pkg::SEQ_RUN)
                    & ~r.output_high_detect & ~fb_above_ov & ~blocked & en;
        mode_edge = mode_pin & ~r.mode_q;
        tick      = r.sync ? mode_edge : (r.osc_cnt == 16'h0000);
        cyc_start = tick & (r.tick_cnt == r.div);
        span      = 19'(r.period) * 19'({1'b0, r.div} + 3'h1);
        max_on    = (span > MIN_OFF) ? span - MIN_OFF : 19'h00000;
        access    = psel & penable & ~r.pready;
        wr        = psel & penable & r.pready & pwrite;
    end

    // one next-state process for the whole block
    always_comb begin
        next_r = r;
        next_r.pg_out = 1'b0;

        // lockout latches with hysteresis
        if (supply_below_lo) begin
            next_r.supply_low_lockout = 1'b1;
        end else if (supply_above_hi) begin
            next_r.supply_low_lockout = 1'b0;
        end
        if (input_above_hi) begin
            next_r.input_high_lockout = 1'b1;
        end else if (input_below_lo) begin
            next_r.input_high_lockout = 1'b0;
        end

        // sequencer: every way back to run passes through soft-start
        case (r.seq)
            bss_pkg::SEQ_OFF: begin
                if (en) begin
                    next_r.seq = bss_pkg::SEQ_LOCK;
                end
            end
            bss_pkg::SEQ_LOCK: begin
                if (!en) begin
                    next_r.seq = bss_pkg::SEQ_OFF;
                end else if (!blocked) begin
                    next_r.seq     = bss_pkg::SEQ_SOFT;
                    next_r.seq_cnt = 20'h00000;
                end
            end
            bss_pkg::SEQ_SOFT, bss_pkg::SEQ_RUN: begin
                if (!en) begin
                    next_r.seq = bss_pkg::SEQ_OFF;
                end else if (blocked) begin
                    next_r.seq = bss_pkg::SEQ_LOCK;
                end else if (current_limit && r.output_low_detect) begin
                    next_r.seq     = bss_pkg::SEQ_HICCUP;
                    next_r.seq_cnt = 20'h00000;
                end else if (r.seq == bss_pkg::SEQ_SOFT) begin
                    if (r.seq_cnt >= 20'(SS_CYCLES - 1)) begin
                        next_r.seq = bss_pkg::SEQ_RUN;
                    end else begin
                        next_r.seq_cnt = r.seq_cnt + 20'h00001;
                    end
                end
            end
            bss_pkg::SEQ_HICCUP: begin
                if (!en) begin
                    next_r.seq = bss_pkg::SEQ_OFF;
                end else if (r.seq_cnt >= 20'(HICCUP_CYCLES - 1)) begin
                    next_r.seq = bss_pkg::SEQ_LOCK;
                end else begin
                    next_r.seq_cnt = r.seq_cnt + 20'h00001;
                end
            end
            default: begin
                next_r.seq = bss_pkg::SEQ_OFF;
            end
        endcase

        // output low detect: qualified on entry, cleared above the release level
        if (r.seq != bss_pkg::SEQ_RUN) begin
            next_r.output_low_detect = 1'b0;
            next_r.uv_cnt            = 10'h000;
        end else if (r.output_low_detect) begin
            if (fb_above_uv_rel) begin
                next_r.output_low_detect = 1'b0;
            end
        end else if (fb_below_uv) begin
            if (r.uv_cnt >= QUAL) begin
                next_r.output_low_detect = 1'b1;
            end else begin
                next_r.uv_cnt = r.uv_cnt + 10'h001;
            end
        end else begin
            next_r.uv_cnt = 10'h000;
        end

        // output high detect: same shape, switching already stopped by the raw flag
        if (r.seq != bss_pkg::SEQ_RUN && r.seq != bss_pkg::SEQ_SOFT) begin
            next_r.output_high_detect = 1'b0;
            next_r.ov_cnt             = 10'h000;
        end else if (r.output_high_detect) begin
            if (fb_below_ov_rel) begin
                next_r.output_high_detect = 1'b0;
                next_r.ov_cnt             = 10'h000;
            end
        end else if (fb_above_ov) begin
            if (r.ov_cnt >= QUAL) begin
                next_r.output_high_detect = 1'b1;
            end else begin
                next_r.ov_cnt = r.ov_cnt + 10'h001;
            end
        end else begin
            next_r.ov_cnt = 10'h000;
        end

        // power-ok: any cause pulls low at once; release waits the full delay
        if (!en || r.seq != bss_pkg::SEQ_RUN || blocked || r.output_low_detect
                || r.output_high_detect) begin
            next_r.pg_oen = 1'b0;
            next_r.pg_cnt = 20'h00000;
        end else if (r.pg_cnt >= 20'(REL_CYCLES - 1)) begin
            next_r.pg_oen = 1'b1;
        end else begin
            next_r.pg_cnt = r.pg_cnt + 20'h00001;
        end

        // sync detect: two edges inside the window mean a clock is present
        next_r.mode_q = mode_pin;
        if (mode_edge) begin
            next_r.sync_win = `BSS_SYNC_WIN_CYC;
            if (r.sync_edges != 2'h3) begin
                next_r.sync_edges = r.sync_edges + 2'h1;
            end
        end else if (r.sync_win != 10'h000) begin
            next_r.sync_win = r.sync_win - 10'h001;
        end else begin
            next_r.sync_edges = 2'h0;
        end

        // free-running oscillator; also restarted by each sync edge, but only while sync is locked
        if (tick) begin
            next_r.osc_cnt  = r.period - 16'h0001;
            next_r.tick_cnt = cyc_start ? 2'h0 : r.tick_cnt + 2'h1;
        end else if (r.osc_cnt != 16'h0000) begin
            next_r.osc_cnt = r.osc_cnt - 16'h0001;
        end

        // duty-over: step the divider by one count at a time, up to 3 or back down to 0
        if (cyc_start) begin
            next_r.min_off_seen = 1'b0;
            if (r.do_cnt >= `BSS_DO_STEP_CYC) begin
                next_r.do_cnt = 4'h0;
                if (r.min_off_seen && r.div != 2'h3) begin
                    next_r.div = r.div + 2'h1;
                end else if (!r.min_off_seen && r.div != 2'h0) begin
                    next_r.div = r.div - 2'h1;
                end
            end else begin
                next_r.do_cnt = r.do_cnt + 4'h1;
            end
        end
        if (min_off_hit) begin
            next_r.min_off_seen = 1'b1;
        end

        // leaving sync on duty-over; sync is kept through soft-start
        next_r.sync = (next_r.sync_edges >= 2'h2) & (next_r.div == 2'h0);
        next_r.forced_pwm = next_r.sync | mode_pin;

        // high-side pulse gating
        if (!sw_ok) begin
            next_r.gate = 1'b0;
        end else if (cyc_start) begin
            if (on_request < MIN_ON) begin
                next_r.gate = 1'b0;
            end else begin
                next_r.gate   = 1'b1;
                next_r.on_cnt = 16'h0001;
                if (19'(on_request) > max_on) begin
                    next_r.on_len       = max_on;
                    next_r.min_off_seen = 1'b1;
                end else begin
                    next_r.on_len = 19'(on_request);
                end
            end
        end else if (r.gate) begin
            next_r.on_cnt = r.on_cnt + 16'h0001;
            if (19'(r.on_cnt) >= r.on_len
                    || (current_limit && r.on_cnt >= MIN_ON)) begin
                next_r.gate = 1'b0;
            end
        end

        // apb: one wait cycle, write lands on the edge that samples pready
        next_r.pready  = access;
        next_r.pslverr = 1'b0;
        if (access) begin
            next_r.prdata = 32'h00000000;
            if (paddr == `BSS_REG_CTRL) begin
                next_r.prdata[`BSS_CTRL_EN_BIT] = r.ctrl_en;
            end else if (paddr == `BSS_REG_PERIOD) begin
                next_r.prdata[15:0] = r.period;
            end else if (paddr == `BSS_REG_STATUS) begin
                next_r.prdata[12:0] = {r.min_off_seen, r.div, r.pg_oen, r.forced_pwm,
                                       r.sync, r.output_high_detect, r.output_low_detect,
                                       r.input_high_lockout, r.supply_low_lockout, r.seq};
            end else begin
                next_r.pslverr = 1'b1;
            end
        end
        if (wr) begin
            if (paddr == `BSS_REG_CTRL && pstrb[0]) begin
                next_r.ctrl_en = pwdata[`BSS_CTRL_EN_BIT];
            end else if (paddr == `BSS_REG_PERIOD) begin
                if (pstrb[0]) begin
                    next_r.period[7:0] = pwdata[7:0];
                end
                if (pstrb[1]) begin
                    next_r.period[15:8] = pwdata[15:8];
                end
            end
        end
    end

    // state register; clock enable low freezes everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r                    <= '0;
            r.seq                <= bss_pkg::SEQ_OFF;
            r.supply_low_lockout <= 1'b1; // locked until the supply proves good
            r.ctrl_en            <= `BSS_CTRL_RESET;
            r.period             <= `BSS_PERIOD_RESET;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // every output straight from the state register
    assign prdata            = r.prdata;
    assign pready            = r.pready;
    assign pslverr           = r.pslverr;
    assign power_ok_flag_out = r.pg_out;
    assign power_ok_flag_oen = r.pg_oen;
    assign forced_pwm        = r.forced_pwm;
    assign sync_locked       = r.sync;
    assign hs_gate           = r.gate;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_hiccup_end;
        r.seq == bss_pkg::SEQ_HICCUP && ce ##1 r.seq == bss_pkg::SEQ_LOCK;
    endsequence

    a_pg_low_soft: assert property ((ce && r.seq == bss_pkg::SEQ_SOFT) |=> !power_ok_flag_oen)
        else $error("power-ok released during soft-start");
    a_no_gate_off: assert property ((ce && !sw_ok) |=> !hs_gate)
        else $error("gate high while switching is stopped");
    a_ov_stops: assert property ((ce && fb_above_ov) |=> !hs_gate)
        else $error("gate high during overvoltage");
    a_hiccup_wait: assert property (s_hiccup_end |-> $past(r.seq_cnt) >= 20'(HICCUP_CYCLES - 1))
        else $error("hiccup ended early");
    a_uv_qualify: assert property ($rose(r.output_low_detect) |-> $past(r.uv_cnt) >= QUAL)
        else $error("output low detect without qualification");
    a_short_skip: assert property ((ce && sw_ok && cyc_start && on_request < MIN_ON && !hs_gate)
                                   |=> !hs_gate)
        else $error("short pulse not skipped");
    a_gate_min_on: assert property ((ce && $rose(hs_gate)) |-> (hs_gate || !sw_ok)[*4])
        else $error("pulse shorter than minimum on-time");
    a_sync_forced: assert property (sync_locked |-> forced_pwm && r.div == 2'h0)
        else $error("sync without forced pwm or during duty-over");
    a_apb_ready: assert property ((ce && psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

endmodule : bss_sequencer

// File: verif/bss_ctrl_model.sv
// system controller model: drives enable and the mode/sync pin of the supervisor
`timescale 1ns/1ns
module bss_ctrl_model #(
    parameter int HALF_CYC = 20
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // commands from the bench
    input  wire logic en_req,
    input  wire logic mode_level,
    input  wire logic sync_on,
    // pins toward the supervisor
    output logic      chip_enable,
    output logic      mode_pin
);
    int cnt;

    // the sync clock runs only while asked for, otherwise the pin is a plain level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt         <= 0;
            mode_pin    <= 1'b0;
            chip_enable <= 1'b0;
        end else begin
            chip_enable <= en_req;
            if (!sync_on) begin
                cnt      <= 0;
                mode_pin <= mode_level;
            end else if (cnt == HALF_CYC - 1) begin
                // a half period of 20 cycles is 400 ns, wide and in range of the set rate
                cnt      <= 0;
                mode_pin <= !mode_pin;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule : bss_ctrl_model

// File: verif/tb_buck_supervisor_sequencer.sv
// self-checking bench for the buck supervisor sequencer
`timescale 1ns/1ns
module tb_buck_supervisor_sequencer;
    localparam int SS  = 50;
    localparam int HIC = 80;
    localparam int REL = 30;
    typedef struct packed {logic err; logic [31:0] msk; logic [31:0] dat;} bss_note_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        chip_enable, mode_pin, power_ok_flag_out, power_ok_flag_oen;
    logic        forced_pwm, sync_locked, hs_gate, current_limit, thermal_hot;
    logic        supply_below_lo, input_above_hi, fb_below_uv, fb_above_ov, min_off_hit;
    logic        en_req, mode_level, sync_on, ce;
    logic [15:0] on_request;
    wire         pg_pin = power_ok_flag_oen ? 1'b1 : power_ok_flag_out;
    bss_note_t   notes[$];
    bss_note_t   note;
    int          err_count, n_tests, gate_cnt, run, last_w, cyc, n, g, req;
    int          seed = 40308;

    // clock and reset
    initial begin
        pclk = 1'b0;
        forever #10 pclk = !pclk;
    end

    bss_sequencer #(.SS_CYCLES(SS), .HICCUP_CYCLES(HIC), .REL_CYCLES(REL)) bss_sequencer_i (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .prdata, .pready, .pslverr, .chip_enable, .mode_pin,
        .power_ok_flag_out, .power_ok_flag_oen, .forced_pwm, .sync_locked,
        .supply_below_lo, .supply_above_hi(!supply_below_lo), .input_above_hi,
        .input_below_lo(!input_above_hi), .fb_below_uv, .fb_above_uv_rel(!fb_below_uv),
        .fb_above_ov, .fb_below_ov_rel(!fb_above_ov), .current_limit, .thermal_hot,
        .min_off_hit, .on_request, .hs_gate);

    bss_ctrl_model #(.HALF_CYC(20)) bss_ctrl_model_i (
        .pclk, .presetn, .en_req, .mode_level, .sync_on, .chip_enable, .mode_pin);

    task automatic cmp_bit(input logic got, input logic exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : cmp_bit

    task automatic stop_test();
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    task automatic ticks(input int k);
        repeat (k) @(posedge pclk);
    endtask : ticks

    // one apb transfer; the expected answer is queued before the request goes out
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic e);
        notes.push_back('{e, m, d});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed; only the bench timeout ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wait_pg(input logic v, input int lim, output int k);
        k = 0;
        while (pg_pin !== v && k < lim) begin
            @(posedge pclk);
            k++;
        end
    endtask : wait_pg

    // wait for the end of a pulse so a shutdown never lands inside the minimum on-time
    task automatic after_pulse();
        while (hs_gate !== 1'b1) @(posedge pclk);
        while (hs_gate === 1'b1) @(posedge pclk);
    endtask : after_pulse

    // apply or remove one shutdown cause; the last one goes through the enable register
    task automatic cause(input int i, input logic v);
        case (i)
            0: input_above_hi <= v;
            1: supply_below_lo <= v;
            2: thermal_hot <= v;
            3: en_req <= !v;
            default: apb(1'b1, 8'h00, {31'h0, !v}, 32'h0, 1'b0);
        endcase
    endtask : cause

    // answer watcher: oldest note against each completed transfer
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                cmp_bit(1'b0, 1'b1, "answer without request");
            end else begin
                note = notes.pop_front();
                cmp_bit(pslverr, note.err, "apb error flag");
                cmp_bit(((prdata ^ note.dat) & note.msk) == 0, 1'b1, "apb read data");
            end
        end
    end

    // gate watcher: pulse widths and a running count of high cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (hs_gate === 1'b1) begin
            run      <= run + 1;
            gate_cnt <= gate_cnt + 1;
        end else if (run > 0) begin
            cmp_bit(run >= 4, 1'b1, "gate pulse below minimum on-time");
            last_w <= run;
            run    <= 0;
        end
        // timeout last, so nothing in this process follows the end of the run
        if (cyc == 40000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, current_limit, thermal_hot} = '0;
        {input_above_hi, fb_below_uv, fb_above_ov, min_off_hit, mode_level, sync_on} = '0;
        {paddr, pwdata, on_request, cyc, gate_cnt, run, last_w} = '0;
        {supply_below_lo, en_req, ce} = 3'b111;
        ticks(4);
        presetn <= 1'b1;
        ticks(2);
        // register reset values, refused address, read-only status
        apb(1'b0, 8'h00, 32'h1, 32'h1, 1'b0);
        apb(1'b0, 8'h04, 32'h64, 32'hffff, 1'b0);
        apb(1'b0, 8'h0c, 32'h0, 32'hffffffff, 1'b1);
        apb(1'b1, 8'h04, 32'h28, 32'h0, 1'b0);
        apb(1'b0, 8'h04, 32'h28, 32'hffff, 1'b0);
        apb(1'b1, 8'h08, 32'hff, 32'h0, 1'b0);
        apb(1'b0, 8'h08, 32'h9, 32'hf, 1'b0);
        // start-up through soft-start, then power ok; clock enable low holds the lockout
        supply_below_lo <= 1'b0;
        ce              <= 1'b0;
        ticks(20);
        ce <= 1'b1;
        wait_pg(1'b1, SS + REL + 20, n);
        cmp_bit(n >= SS + REL && n <= SS + REL + 8, 1'b1, "start-up delay");
        apb(1'b0, 8'h08, 32'h203, 32'h207, 1'b0);
        // pulse widths follow the request
        for (int i = 0; i < 3; i++) begin
            req = 4 + ($unsigned($random(seed)) % 20);
            on_request <= 16'(req);
            ticks(100);
            cmp_bit(last_w == req, 1'b1, "gate width");
        end
        on_request <= 16'h0003;
        ticks(45);
        g = gate_cnt;
        ticks(100);
        cmp_bit(gate_cnt == g, 1'b1, "short request not skipped");
        on_request <= 16'h001e;
        current_limit <= 1'b1;
        ticks(100);
        cmp_bit(last_w >= 4 && last_w < 30, 1'b1, "current limit cut");
        current_limit <= 1'b0;
        // mode level, sync clock, duty-over
        mode_level <= 1'b1;
        ticks(5);
        cmp_bit(forced_pwm, 1'b1, "forced pwm on high pin");
        mode_level <= 1'b0;
        ticks(5);
        cmp_bit(forced_pwm, 1'b0, "auto mode on low pin");
        sync_on <= 1'b1;
        ticks(300);
        cmp_bit(sync_locked & forced_pwm, 1'b1, "sync lock");
        min_off_hit <= 1'b1;
        ticks(2500);
        cmp_bit(sync_locked, 1'b0, "sync kept in duty-over");
        apb(1'b0, 8'h08, 32'h1c00, 32'h1c00, 1'b0);
        {min_off_hit, sync_on} <= 2'b00;
        // feedback overvoltage
        on_request <= 16'h000a;
        ticks(200);
        after_pulse();
        fb_above_ov <= 1'b1;
        ticks(2);
        g = gate_cnt;
        ticks(100);
        cmp_bit(gate_cnt == g, 1'b1, "switching on overvoltage");
        wait_pg(1'b0, 800, n);
        cmp_bit(n > 600 && n < 800, 1'b1, "overvoltage qualify");
        fb_above_ov <= 1'b0;
        wait_pg(1'b1, REL + 20, n);
        cmp_bit(n >= REL, 1'b1, "overvoltage release delay");
        g = gate_cnt;
        ticks(100);
        cmp_bit(gate_cnt > g, 1'b1, "switching not resumed");
        // output undervoltage, then current limit into hiccup
        fb_below_uv <= 1'b1;
        wait_pg(1'b0, 800, n);
        cmp_bit(n >= 745 && n <= 760, 1'b1, "undervoltage qualify");
        after_pulse();
        current_limit <= 1'b1;
        ticks(2);
        apb(1'b0, 8'h08, 32'h4, 32'h207, 1'b0);
        {current_limit, fb_below_uv} <= 2'b00;
        wait_pg(1'b1, HIC + SS + REL + 40, n);
        cmp_bit(n >= HIC - 10 + SS + REL, 1'b1, "hiccup restart");
        // each shutdown cause pulls power ok low and restarts through soft-start
        for (int i = 0; i < 5; i++) begin
            after_pulse();
            cause(i, 1'b1);
            wait_pg(1'b0, 10, n);
            cmp_bit(n < 10, 1'b1, "power ok not pulled low");
            g = gate_cnt;
            ticks(50);
            cmp_bit(gate_cnt == g, 1'b1, "switching while shut down");
            if (i < 3) apb(1'b0, 8'h08, 32'h1, 32'h7, 1'b0);
            cause(i, 1'b0);
            wait_pg(1'b1, SS + REL + 20, n);
            cmp_bit(n >= SS + REL && n < SS + REL + 20, 1'b1, "restart");
        end
        stop_test();
    end
endmodule : tb_buck_supervisor_sequencer
